// ==== src/rpm_top.v ====
// Configuration access port with adaptation loop monitor.
`include "rpm_defs.vh"
`timescale 1ns/100ps
module rpm_top
(
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst_n,
  // Configuration access port.
  input wire i_access_strobe,
  input wire i_write_select,
  input wire [9:0] i_config_address_bus,
  input wire [15:0] i_config_write_data,
  output reg [15:0] o_config_read_data,
  output reg o_completion_flag,
  input wire i_port_reset,
  // Internal parallel clock activity, asynchronous.
  input wire i_parallel_clock_alive,
  // Monitor side.
  input wire i_monitor_fifo_reset,
  input wire [6:0] i_feedback_code,
  input wire [6:0] i_lowpower_code,
  output reg [15:0] o_monitor_out,
  output reg o_loop_clock_output
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_HANG = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] count;
  reg [2:0] next_count;
  reg pend_wr;
  reg [1:0] pend_idx;
  reg pend_hit;
  reg [15:0] pend_data;
  reg [15:0] wr_data_q;
  reg mem_wr;
  reg [15:0] monen;
  reg [15:0] lpm_cfg;
  reg [15:0] dfe_cfg;
  reg [15:0] adapt_cfg;
  reg [3:0] div_cnt;
  reg [15:0] next_mon;
  reg [6:0] fb_s1;
  reg [6:0] fb_s2;
  reg [6:0] fb_s3;
  reg [6:0] fb_code;
  reg [6:0] lp_s1;
  reg [6:0] lp_s2;
  reg [6:0] lp_s3;
  reg [6:0] lp_code;
  wire [15:0] mem_rd;
  wire clk_alive;
  wire access;
  wire [2:0] acc_code;
  wire [1:0] acc_idx;
  wire acc_hit;
  wire mon_on;
  wire dfe_sel;

  // ********************
  // Address decode.
  // ********************
  function [2:0] decode;
    input [9:0] addr;
    begin
      case (addr)
        `RPM_ADDR_MONEN: decode = 3'h4;
        `RPM_ADDR_LPM: decode = 3'h5;
        `RPM_ADDR_DFE: decode = 3'h6;
        `RPM_ADDR_ADAPT: decode = 3'h7;
        default: decode = 3'h0;
      endcase
    end
  endfunction

  assign access = i_access_strobe && state == ST_IDLE;
  assign acc_code = decode(i_config_address_bus);
  assign acc_hit = acc_code != 3'h0;
  assign acc_idx = acc_code[1:0];

  rpm_sync3 u_alive
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_parallel_clock_alive),
    .o_level(clk_alive)
  );

  rpm_cfg_mem u_mem
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(mem_wr),
    .i_wr_idx(pend_idx),
    .i_wr_data(wr_data_q),
    .i_rd_idx(pend_idx),
    .o_rd_data(mem_rd)
  );

  // ********************
  // Transaction sequencer.
  // ********************
  always @*
  begin
    next_state = state;
    next_count = count;
    case (state)
      ST_IDLE:
      begin
        if (access)
        begin
          next_count = 3'h1;
          if (!i_write_select && !acc_hit && !clk_alive)
            next_state = ST_HANG;
          else
            next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        next_count = count + 3'h1;
        if (count == `RPM_RW_LAT)
          next_state = ST_IDLE;
      end
      ST_HANG:
        next_state = ST_HANG;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n || i_port_reset)
    begin
      state <= ST_IDLE;
      count <= 3'h0;
      pend_wr <= 1'b0;
      pend_idx <= 2'h0;
      pend_hit <= 1'b0;
      wr_data_q <= 16'h0000;
      mem_wr <= 1'b0;
      o_completion_flag <= 1'b0;
      o_config_read_data <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      mem_wr <= 1'b0;
      if (access)
      begin
        pend_wr <= i_write_select;
        pend_idx <= acc_idx;
        pend_hit <= acc_hit;
        wr_data_q <= i_config_write_data;
        mem_wr <= i_write_select && acc_hit;
      end
      o_completion_flag <= state == ST_WAIT &&
        count == `RPM_RW_LAT - 3'h1;
      if (state == ST_WAIT && count == `RPM_RW_LAT - 3'h1)
        o_config_read_data <= (pend_hit && !pend_wr) ? pend_data
          : 16'h0000;
    end
  end

  // Read data from the memory, monitor enable word reads back its high byte only, low byte zero.
  always @*
  begin
    pend_data = mem_rd;
    if (pend_idx == 2'h0)
      pend_data = {mem_rd[15:8], 8'h00};
  end

  // ********************
  // Monitor configuration shadow.
  // ********************
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      monen <= `RPM_RST_MONEN;
      lpm_cfg <= `RPM_RST_LPM;
      dfe_cfg <= `RPM_RST_DFE;
      adapt_cfg <= `RPM_RST_ADAPT;
    end
    else if (mem_wr)
    begin
      case (pend_idx)
        2'h0: monen <= wr_data_q;
        2'h1: lpm_cfg <= wr_data_q;
        2'h2: dfe_cfg <= wr_data_q;
        default: adapt_cfg <= wr_data_q;
      endcase
    end
  end

  assign mon_on = monen[`RPM_MONEN_BIT] && adapt_cfg[`RPM_ADAPT_HI] &&
    !adapt_cfg[`RPM_ADAPT_LO1];
  assign dfe_sel = dfe_cfg[`RPM_EN_BIT];

  // ********************
  // Loop code synchronisers.
  // ********************
  // A code moves on only when the last two stages agree, so a word caught
  // in mid-change is never placed on the monitor output.
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      fb_s1 <= 7'h00;
      fb_s2 <= 7'h00;
      fb_s3 <= 7'h00;
      fb_code <= 7'h00;
      lp_s1 <= 7'h00;
      lp_s2 <= 7'h00;
      lp_s3 <= 7'h00;
      lp_code <= 7'h00;
    end
    else
    begin
      fb_s1 <= i_feedback_code;
      fb_s2 <= fb_s1;
      fb_s3 <= fb_s2;
      if (fb_s2 == fb_s3)
        fb_code <= fb_s3;
      lp_s1 <= i_lowpower_code;
      lp_s2 <= lp_s1;
      lp_s3 <= lp_s2;
      if (lp_s2 == lp_s3)
        lp_code <= lp_s3;
    end
  end

  // ********************
  // Loop selection and placement.
  // ********************
  always @*
  begin
    next_mon = 16'h0000;
    if (mon_on && dfe_sel)
    begin
      case (dfe_cfg[4:0])
        `RPM_DFE_OS, `RPM_DFE_VP, `RPM_DFE_UT:
          next_mon = {9'h000, fb_code};
        `RPM_DFE_KL, `RPM_DFE_KH:
          next_mon = {9'h000, fb_code[4:0], 2'h0};
        `RPM_DFE_TAP2, `RPM_DFE_TAP3:
          next_mon = {9'h000, fb_code[5:0], 1'b0};
        default:
          if (dfe_cfg[4:0] <= `RPM_DFE_TAPF)
            next_mon = {11'h000, fb_code[4:0]};
      endcase
    end
    else if (mon_on && lpm_cfg[`RPM_EN_BIT])
    begin
      case (lpm_cfg[4:3])
        `RPM_LPM_KH, `RPM_LPM_KL:
          next_mon = {9'h000, lp_code[4:0], 2'h0};
        `RPM_LPM_OS:
          next_mon = {9'h000, lp_code};
        default:
          next_mon = {11'h000, lp_code[4:0]};
      endcase
    end
  end

  // ********************
  // Monitor output.
  // ********************
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n || i_monitor_fifo_reset)
      o_monitor_out <= 16'h0000;
    else
      o_monitor_out <= next_mon;
  end

  // ********************
  // Loop clock divider.
  // ********************
  // The divider ignores the monitor clear so the loop clock keeps its period.
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      div_cnt <= 4'h0;
      o_loop_clock_output <= 1'b0;
    end
    else if (div_cnt == `RPM_LOOP_CLK_DIV)
    begin
      div_cnt <= 4'h0;
      o_loop_clock_output <= !o_loop_clock_output;
    end
    else
      div_cnt <= div_cnt + 4'h1;
  end

endmodule

// ==== src/rpm_defs.vh ====
// Constants for the configuration access port and adaptation monitor.
//
// Contract
// - No access unless strobe; select picks read/write.
// - Completion pulse marks write done or data valid.
// - Channel read/write register completes six cycles later.
// - Common block completes six to seven cycles later.
// - Read-only read with stopped clock hangs port.
// - Data buses 16 bits; address 10 bits channel.
// - Adaptation field [12:8] picks low-power or feedback; code ignores [12:8], feedback word bit 5 picks.
// - Feedback loop code [4:0], bit 5 enables monitoring.
// - Offset loops: 7-bit signed, neutral 63 and 64.
// - Tap three: 6-bit signed, neutral 31 and 32.
// - Taps four to F: 5-bit signed, neutral 15, 16.
// - Unsigned loops read zero to full scale.
// - Low-power monitor: bit 5 enable, [4:3] loop.
// - Output placement: [6:0], [6:2], [6:1], [4:0].
`ifndef RPM_DEFS_VH
`define RPM_DEFS_VH
`define RPM_ADDR_W 10
`define RPM_DATA_W 16
`define RPM_MON_W 16
`define RPM_ADDR_MONEN 10'h03a
`define RPM_ADDR_LPM 10'h032
`define RPM_ADDR_DFE 10'h054
`define RPM_ADDR_ADAPT 10'h092
`define RPM_RW_LAT 3'h6
`define RPM_EN_BIT 5
`define RPM_MONEN_BIT 8
`define RPM_ADAPT_HI 15
`define RPM_ADAPT_LO1 1
`define RPM_RST_MONEN 16'h0000
`define RPM_RST_LPM 16'h0000
`define RPM_RST_DFE 16'h0000
`define RPM_RST_ADAPT 16'h0000
`define RPM_LPM_KH 2'h0
`define RPM_LPM_KL 2'h1
`define RPM_LPM_OS 2'h2
`define RPM_LPM_AGC 2'h3
`define RPM_DFE_OS 5'h00
`define RPM_DFE_KL 5'h01
`define RPM_DFE_KH 5'h02
`define RPM_DFE_VP 5'h03
`define RPM_DFE_UT 5'h04
`define RPM_DFE_AGC 5'h05
`define RPM_DFE_TAP2 5'h06
`define RPM_DFE_TAP3 5'h07
`define RPM_DFE_TAPF 5'h13
`define RPM_LOOP_CLK_DIV 4'h7
`endif

// ==== src/rpm_cfg_mem.v ====
// Small register memory holding the four configuration words.
`timescale 1ns/100ps
module rpm_cfg_mem
(
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst_n,
  // Write side.
  input wire i_wr,
  input wire [1:0] i_wr_idx,
  input wire [15:0] i_wr_data,
  // Read side.
  input wire [1:0] i_rd_idx,
  output reg [15:0] o_rd_data
);

  reg [15:0] mem [0:3];
  genvar g;

  // ********************
  // Storage words.
  // ********************
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_word
      always @(posedge i_sys_clk)
      begin
        if (!i_rst_n)
          mem[g] <= 16'h0000;
        else if (i_wr && i_wr_idx == g)
          mem[g] <= i_wr_data;
      end
    end
  endgenerate

  // ********************
  // Registered read data.
  // ********************
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_rd_data <= 16'h0000;
    else
      o_rd_data <= mem[i_rd_idx];
  end

endmodule

// ==== src/rpm_sync3.v ====
// Three-stage synchroniser that accepts a change when stages agree.
`timescale 1ns/100ps
module rpm_sync3
(
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst_n,
  // Asynchronous level in, clean level out.
  input wire i_async,
  output reg o_level
);

  reg s1;
  reg s2;
  reg s3;

  // ********************
  // Synchroniser chain.
  // ********************
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        o_level <= s3;
    end
  end

endmodule

// ==== test/rpm_top_assertions.sv ====
// Checker for the access port and monitor outputs.
`timescale 1ns/100ps
module rpm_top_chk
(
  // Clock, reset and requests.
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_access_strobe,
  input wire i_write_select,
  input wire i_port_reset,
  input wire i_monitor_fifo_reset,
  // Answers.
  input wire [15:0] o_config_read_data,
  input wire o_completion_flag,
  input wire [15:0] o_monitor_out,
  input wire o_loop_clock_output
);
  reg pend;
  wire take = i_access_strobe & ~pend;
  always @(posedge i_sys_clk)
    if (!i_rst_n || i_port_reset || o_completion_flag)
      pend <= 1'b0;
    else if (i_access_strobe)
      pend <= 1'b1;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_flag_six:
    assert property (take && i_write_select |=>
      !o_completion_flag[*5] ##1 o_completion_flag)
    else $error("completion not six cycles after write");
  chk_flag_single:
    assert property (o_completion_flag |=> !o_completion_flag)
    else $error("completion longer than one cycle");
  chk_flag_cause:
    assert property (o_completion_flag |-> $past(take, 6))
    else $error("completion without a taken strobe");
  chk_idle_quiet:
    assert property (!pend && !i_access_strobe |=> !o_completion_flag)
    else $error("completion while idle");
  chk_rdata_hold:
    assert property ($changed(o_config_read_data) |-> o_completion_flag)
    else $error("read data changed outside completion");
  chk_loop_clk:
    assert property ($changed(o_loop_clock_output) |=>
      $stable(o_loop_clock_output)[*7] ##1 $changed(o_loop_clock_output))
    else $error("loop clock period wrong");
  chk_fifo_clear:
    assert property (i_monitor_fifo_reset |=> o_monitor_out == 16'h0000)
    else $error("monitor not cleared");
  chk_mon_upper:
    assert property (o_monitor_out[15:7] == 9'h000)
    else $error("monitor upper bits set");
endmodule
bind rpm_top rpm_top_chk i_rpm_top_chk (.i_sys_clk, .i_rst_n,
  .i_access_strobe, .i_write_select, .i_port_reset, .i_monitor_fifo_reset,
  .o_config_read_data, .o_completion_flag, .o_monitor_out,
  .o_loop_clock_output);

// ==== test/rpm_ctrl_model.sv ====
// Model of the fabric controller driving the access port.
`timescale 1ns/100ps
module rpm_ctrl_model
(
  // Clock and answer.
  input wire i_sys_clk,
  input wire i_completion_flag,
  input wire [15:0] i_read_data,
  // Requests.
  output reg o_strobe,
  output reg o_we,
  output reg [9:0] o_addr,
  output reg [15:0] o_wdata,
  output reg o_port_reset
);
  initial
  begin
    o_strobe = 1'b0;
    o_we = 1'b0;
    o_addr = 10'h000;
    o_wdata = 16'h0000;
    o_port_reset = 1'b0;
  end
  task xfer(input w, input [9:0] a, input [15:0] d,
    output [15:0] rd, output integer lat);
    integer n;
    begin
      @(posedge i_sys_clk);
      #1;
      o_strobe = 1'b1;
      o_we = w;
      o_addr = a;
      o_wdata = d;
      @(posedge i_sys_clk);
      #1;
      o_strobe = 1'b0;
      o_we = ~w;
      o_addr = ~a;
      o_wdata = ~d;
      lat = 0;
      n = 0;
      while (lat == 0 && n < 500)
      begin
        @(posedge i_sys_clk);
        n = n + 1;
        if (i_completion_flag === 1'b1)
        begin
          lat = n;
          rd = i_read_data;
        end
      end
      if (lat == 0)
      begin
        #1;
        o_port_reset = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_port_reset = 1'b0;
      end
    end
  endtask
endmodule

// ==== test/rpm_top_test.sv ====
// Self-checking bench for the access port and adaptation monitor.
`timescale 1ns/100ps
module rpm_top_test;
  reg clk, rst_n, alive, fifo_rst;
  reg [6:0] fb_code, lp_code;
  reg [15:0] rd, d;
  wire strobe, we, flag, port_rst, loop_clk;
  wire [9:0] addr;
  wire [15:0] wdata, rdata, mon;
  wire [39:0] ra = {10'h092, 10'h054, 10'h032, 10'h03a};
  integer fails, num_checks, lat, k;
  rpm_top i_rpm_top (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_access_strobe(strobe), .i_write_select(we),
    .i_config_address_bus(addr), .i_config_write_data(wdata),
    .o_config_read_data(rdata), .o_completion_flag(flag),
    .i_port_reset(port_rst), .i_parallel_clock_alive(alive),
    .i_monitor_fifo_reset(fifo_rst), .i_feedback_code(fb_code),
    .i_lowpower_code(lp_code), .o_monitor_out(mon),
    .o_loop_clock_output(loop_clk));
  rpm_ctrl_model i_rpm_ctrl_model (.i_sys_clk(clk),
    .i_completion_flag(flag), .i_read_data(rdata), .o_strobe(strobe),
    .o_we(we), .o_addr(addr), .o_wdata(wdata), .o_port_reset(port_rst));
  task compare(input string name, input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("BAD %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task end_of_test;
    begin
      if (fails == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task xchk(input w, input [9:0] a, input [15:0] dv, input [15:0] exp);
    begin
      i_rpm_ctrl_model.xfer(w, a, dv, rd, lat);
      compare("latency", lat[15:0], 16'h0006);
      if (!w)
        compare("read data", rd, exp);
    end
  endtask
  function [15:0] exp_fb(input [4:0] s, input [6:0] c);
    case (s)
      5'h00, 5'h03, 5'h04: exp_fb = {9'h000, c};
      5'h01, 5'h02: exp_fb = {9'h000, c[4:0], 2'h0};
      5'h06, 5'h07: exp_fb = {9'h000, c[5:0], 1'h0};
      default: exp_fb = (s > 5'h13) ? 16'h0000 : {11'h000, c[4:0]};
    endcase
  endfunction
  function [15:0] exp_lp(input [1:0] s, input [6:0] c);
    if (s < 2'h2)
      exp_lp = {9'h000, c[4:0], 2'h0};
    else
      exp_lp = (s == 2'h2) ? {9'h000, c} : {11'h000, c[4:0]};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #1000000;
    fails = fails + 1;
    end_of_test;
  end
  initial
  begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    alive = 1'b1;
    fifo_rst = 1'b0;
    fb_code = 7'h00;
    lp_code = 7'h00;
    k = $urandom(21271);
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    for (k = 0; k < 4; k = k + 1)
      xchk(1'b0, ra[k*10 +: 10], 16'h0000, 16'h0000);
    for (k = 0; k < 4; k = k + 1)
    begin
      d = $urandom;
      xchk(1'b1, ra[k*10 +: 10], d, 16'h0000);
      xchk(1'b0, ra[k*10 +: 10], 16'h0000, k ? d : d & 16'hff00);
    end
    xchk(1'b1, 10'h100, $urandom, 16'h0000);
    xchk(1'b0, 10'h100, 16'h0000, 16'h0000);
    xchk(1'b1, 10'h03a, 16'h0100, 16'h0000);
    xchk(1'b1, 10'h092, 16'h8000, 16'h0000);
    xchk(1'b1, 10'h054, 16'h0000, 16'h0000);
    for (k = 0; k < 4; k = k + 1)
    begin
      #1 lp_code = $urandom;
      xchk(1'b1, 10'h032, 16'h0020 | (k << 3), 16'h0000);
      repeat (8) @(posedge clk);
      compare("lowpower", mon, exp_lp(k, lp_code));
    end
    for (k = 0; k < 21; k = k + 1)
    begin
      #1 fb_code = k[0] ? 7'h3f + k[1] : $urandom;
      xchk(1'b1, 10'h054, 16'h0020 | k, 16'h0000);
      repeat (8) @(posedge clk);
      compare("feedback", mon, exp_fb(k, fb_code));
    end
    #1 fb_code = 7'h5a;
    xchk(1'b1, 10'h054, 16'h0020, 16'h0000);
    xchk(1'b1, 10'h092, 16'h8002, 16'h0000);
    repeat (8) @(posedge clk);
    compare("adapt off", mon, 16'h0000);
    xchk(1'b1, 10'h092, 16'h8000, 16'h0000);
    repeat (8) @(posedge clk);
    compare("adapt on", mon, 16'h005a);
    #1 fifo_rst = 1'b1;
    @(posedge clk);
    #1 compare("fifo reset", mon, 16'h0000);
    fifo_rst = 1'b0;
    alive = 1'b0;
    repeat (8) @(posedge clk);
    i_rpm_ctrl_model.xfer(1'b0, 10'h1f0, 16'h0000, rd, lat);
    compare("hang", lat[15:0], 16'h0000);
    #1 alive = 1'b1;
    repeat (8) @(posedge clk);
    xchk(1'b0, 10'h054, 16'h0000, 16'h0020);
    end_of_test;
  end
endmodule
